// *** rtl/eeprom_ctl.sv ***
// Purpose: register control for a byte-wide on-chip data array
// Assumes: one core register access per cycle, addresses are core file addresses
// Notes:   array storage is held here as a register array
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_ctl_consts.svh"

module eeprom_ctl #(
    parameter int unsigned WRITE_CYCLES = `WRITE_CYCLES,
    parameter bit          LARGE        = 1'b1
) (
    input  wire logic                    core_clk,
    input  wire logic                    rst,
    input  wire logic                    por,
    input  wire logic                    abort_reset,
    input  wire eeprom_ctl_pkg::sfr_req_s req,
    output logic [7:0]                   rdata,
    output logic                         write_done_flag,
    input  wire logic                    write_done_clr,
    output logic                         write_busy
);
    // ****************************************
    // state
    // ****************************************
    logic [7:0]  array_q [256];
    logic [7:0]  array_data_reg_q;
    logic [7:0]  array_address_reg_q;
    logic        rd_q;
    logic        permit_q;
    logic        abort_q;
    logic        done_q;
    logic [1:0]  key_step_q;
    logic [2:0]  key_gap_q;
    logic [31:0] timer_q;
    eeprom_ctl_pkg::wr_state_e state_q;

    // ****************************************
    // decode
    // ****************************************
    wire wr_data   = req.wr && req.addr == `ADDR_DATA_REG;
    wire wr_adr    = req.wr && req.addr == `ADDR_ADDRESS_REG;
    wire wr_ctl    = req.wr && req.addr == `ADDR_CONTROL_REG;
    wire wr_key    = req.wr && req.addr == `ADDR_UNLOCK_KEY;
    wire busy      = state_q != eeprom_ctl_pkg::ST_IDLE;
    wire unlocked  = key_step_q == 2'h2 && key_gap_q == `KEY_WINDOW;
    wire wr_start  = wr_ctl && req.wdata[`BIT_WR] && !busy
                     && permit_q && unlocked;
    wire rd_start  = wr_ctl && req.wdata[`BIT_RD] && !busy;
    wire timer_end = timer_q == 32'h0;
    wire [7:0] eff_addr = LARGE ? array_address_reg_q
                                : {1'b0, array_address_reg_q[6:0]};
    wire [7:0] ctl_val = {4'h0, abort_q, permit_q, busy, rd_q};

    // register read mux, key port reads zero
    always_comb begin
        case (req.addr)
            `ADDR_DATA_REG:    rdata = array_data_reg_q;
            `ADDR_ADDRESS_REG: rdata = array_address_reg_q;
            `ADDR_CONTROL_REG: rdata = ctl_val;
            default:           rdata = 8'h00;
        endcase
    end
    assign write_done_flag = done_q;
    assign write_busy      = busy;

    // ****************************************
    // unlock detector
    // ****************************************
    // a 55h write always restarts the sequence; an AAh write is
    // taken only at the exact gap, any other key or control write
    // drops back to the start so a stray store cannot arm a write
    always_ff @(posedge core_clk) begin
        if (rst) begin
            key_step_q <= 2'h0;
            key_gap_q  <= 3'h0;
        end else if (wr_key && req.wdata == `KEY_FIRST) begin
            key_step_q <= 2'h1;
            key_gap_q  <= 3'h0;
        end else if (wr_key && key_step_q == 2'h1 && req.wdata == `KEY_SECOND
                     && key_gap_q == `KEY_WINDOW) begin
            key_step_q <= 2'h2;
            key_gap_q  <= 3'h0;
        end else if (wr_key || wr_ctl || key_gap_q == 3'h7) begin
            key_step_q <= 2'h0;
            key_gap_q  <= 3'h0;
        end else if (key_step_q != 2'h0) begin
            key_gap_q  <= key_gap_q + 3'h1;
        end
    end

    // ****************************************
    // control bits
    // ****************************************
    // power-on clears everything; other resets keep the abort flag
    // and set it when a reset with abort_reset high cuts a timed write short
    always_ff @(posedge core_clk) begin
        if (por) begin
            permit_q <= 1'b0;
            abort_q  <= 1'b0;
            rd_q     <= 1'b0;
        end else if (rst) begin
            permit_q <= 1'b0;
            abort_q  <= abort_q | (abort_reset && busy);
            rd_q     <= 1'b0;
        end else begin
            rd_q <= rd_start;
            if (wr_ctl) begin
                permit_q <= req.wdata[`BIT_PERMIT];
                abort_q  <= req.wdata[`BIT_ABORT];
            end
        end
    end

    // done flag, set wins over clear
    always_ff @(posedge core_clk) begin
        if (rst) begin
            done_q <= 1'b0;
        end else begin
            done_q <= (state_q == eeprom_ctl_pkg::ST_PROG && timer_end)
                      || (done_q && !write_done_clr);
        end
    end

    // ****************************************
    // timed write sequencer
    // ****************************************
    // erase takes half the write time, rounded down, and program the rest; the address
    // register is frozen while busy so both phases hit one location
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= eeprom_ctl_pkg::ST_IDLE;
            timer_q <= 32'h0;
        end else begin
            case (state_q)
                eeprom_ctl_pkg::ST_IDLE: begin
                    if (wr_start) begin
                        state_q <= eeprom_ctl_pkg::ST_ERASE;
                        timer_q <= WRITE_CYCLES / 2;
                    end
                end
                eeprom_ctl_pkg::ST_ERASE: begin
                    if (timer_end) begin
                        array_q[eff_addr] <= 8'hFF;
                        state_q <= eeprom_ctl_pkg::ST_PROG;
                        timer_q <= WRITE_CYCLES - WRITE_CYCLES / 2;
                    end else begin
                        timer_q <= timer_q - 32'h1;
                    end
                end
                eeprom_ctl_pkg::ST_PROG: begin
                    if (timer_end) begin
                        array_q[eff_addr] <= array_data_reg_q;
                        state_q <= eeprom_ctl_pkg::ST_IDLE;
                    end else begin
                        timer_q <= timer_q - 32'h1;
                    end
                end
                default: state_q <= eeprom_ctl_pkg::ST_IDLE;
            endcase
        end
    end

    // data and address registers, untouched by reset
    // no reset here so software can retry a write cut by reset
    always_ff @(posedge core_clk) begin
        if (!rst && rd_start) begin
            array_data_reg_q <= array_q[eff_addr];
        end else if (!rst && wr_data) begin
            array_data_reg_q <= req.wdata;
        end
        if (!rst && wr_adr && !busy) begin
            array_address_reg_q <= req.wdata;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    rd_lands_a: assert property (@(posedge core_clk) disable iff (rst)
        rd_start |=> array_data_reg_q == $past(array_q[eff_addr]) && rd_q)
        else $error("read data not loaded");
    rd_clears_a: assert property (@(posedge core_clk) disable iff (rst)
        rd_q && !rd_start |=> !rd_q) else $error("read trigger stuck");
    hi_zero_a: assert property (@(posedge core_clk) disable iff (rst)
        req.addr == `ADDR_CONTROL_REG |-> rdata[7:4] == 4'h0)
        else $error("control high bits set");
    key_zero_a: assert property (@(posedge core_clk) disable iff (rst)
        req.addr == `ADDR_UNLOCK_KEY |-> rdata == 8'h00)
        else $error("key port read nonzero");
    no_permit_a: assert property (@(posedge core_clk) disable iff (rst)
        !busy && !permit_q |=> !busy) else $error("write without permit");
    no_key_a: assert property (@(posedge core_clk) disable iff (rst)
        !busy && !unlocked |=> !busy) else $error("write without unlock");
    // reset drops busy without completing a write, so exclude it
    done_set_a: assert property (@(posedge core_clk) disable iff (rst)
        $fell(busy) && !$past(rst) |-> done_q) else $error("done flag not set");
    busy_hold_a: assert property (@(posedge core_clk) disable iff (rst)
        $rose(busy) |=> busy[*8]) else $error("write ended early");
    small_adr_a: assert property (@(posedge core_clk) disable iff (rst)
        !LARGE |-> !eff_addr[7]) else $error("small variant top bit");
endmodule
`default_nettype wire

// *** rtl/eeprom_ctl_consts.svh ***
// Purpose: constants for the data array access control block
// Assumes: byte-wide special register port of the processor core
// Notes:   offsets are the register file addresses of the core
`ifndef EEPROM_CTL_CONSTS_SVH
`define EEPROM_CTL_CONSTS_SVH
`define ADDR_DATA_REG    8'h9A
`define ADDR_ADDRESS_REG 8'h9B
`define ADDR_CONTROL_REG 8'h9C
`define ADDR_UNLOCK_KEY  8'h9D
`define BIT_RD           0
`define BIT_WR           1
`define BIT_PERMIT       2
`define BIT_ABORT        3
`define KEY_FIRST        8'h55
`define KEY_SECOND       8'hAA
`define KEY_WINDOW       3'h2
`define WRITE_TIME_NS    4000000
`define CLK_PERIOD_NS    4
`define WRITE_CYCLES     (`WRITE_TIME_NS / `CLK_PERIOD_NS)
`endif

// *** rtl/eeprom_ctl_pkg.sv ***
// Purpose: types for the data array access control block
// Assumes: constants live in eeprom_ctl_consts.svh
// Notes:   none
`default_nettype none
package eeprom_ctl_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_ERASE = 3'b010,
        ST_PROG  = 3'b100
    } wr_state_e;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_s;
endpackage
`default_nettype wire

// *** verif/data_eeprom_access_control_bench.sv ***
// Purpose: self-checking bench for the data array access control block
// Assumes: short write time parameter, large variant
// Notes:   inputs change on the falling edge of core_clk
`timescale 1ns/1ps
`default_nettype none
module data_eeprom_access_control_bench;
    // ****************************************
    // signals and design
    // ****************************************
    logic                     core_clk       = 1'b0;
    logic                     rst            = 1'b1;
    logic                     por            = 1'b1;
    logic                     abort_reset    = 1'b0;
    logic                     write_done_clr = 1'b0;
    eeprom_ctl_pkg::sfr_req_s req            = '0;
    logic [7:0]               rdata;
    logic                     write_done_flag;
    logic                     write_busy;
    int                       err_total      = 0;
    int                       total_checks   = 0;

    eeprom_ctl #(.WRITE_CYCLES(20), .LARGE(1'b1)) i_dut (
        .core_clk        (core_clk),
        .rst             (rst),
        .por             (por),
        .abort_reset     (abort_reset),
        .req             (req),
        .rdata           (rdata),
        .write_done_flag (write_done_flag),
        .write_done_clr  (write_done_clr),
        .write_busy      (write_busy)
    );

    // 250 MHz clock
    always #2 core_clk = ~core_clk;

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one strobe cycle then one idle cycle, entered and left at a falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge core_clk);
        req.wr = 1'b0;
        @(negedge core_clk);
    endtask
    // combinational read, next drive waits for the falling edge
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
        req.addr = a;
        #1;
        chk(rdata & m, exp);
        @(negedge core_clk);
    endtask
    // gap counts idle cycles between key writes, one is inside wr
    task automatic unlock(input int gap, input logic [7:0] ctl);
        wr(8'h9D, 8'h55);
        repeat (gap - 1) @(negedge core_clk);
        wr(8'h9D, 8'hAA);
        repeat (gap - 1) @(negedge core_clk);
        wr(8'h9C, ctl);
        @(negedge core_clk);
    endtask
    task automatic full_write(input logic [7:0] a, input logic [7:0] d);
        wr(8'h9C, 8'h04);
        wr(8'h9B, a);
        wr(8'h9A, d);
        unlock(2, 8'h06);
    endtask
    task automatic wait_idle;
        for (int i = 0; i < 100 && write_busy !== 1'b0; i++) @(negedge core_clk);
    endtask
    task automatic readback(input logic [7:0] a, input logic [7:0] exp);
        wr(8'h9B, a);
        wr(8'h9C, 8'h01);
        @(negedge core_clk);
        rd(8'h9A, 8'hFF, exp);
        rd(8'h9C, 8'h01, 8'h00);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        rd(8'h9C, 8'hFF, 8'h00);
        rd(8'h9D, 8'hFF, 8'h00);
        rd(8'h9E, 8'hFF, 8'h00);
        chk({7'h0, write_done_flag}, 8'h00);
        $display("reset test done");
    endtask
    task automatic t_write;
        full_write(8'h81, 8'h5A);
        chk({7'h0, write_busy}, 8'h01);
        rd(8'h9C, 8'hFF, 8'h06);
        wr(8'h9C, 8'h04);
        wr(8'h9C, 8'h00);
        chk({7'h0, write_busy}, 8'h01);
        wait_idle();
        chk({7'h0, write_busy}, 8'h00);
        rd(8'h9C, 8'h02, 8'h00);
        chk({7'h0, write_done_flag}, 8'h01);
        write_done_clr = 1'b1;
        @(negedge core_clk);
        write_done_clr = 1'b0;
        chk({7'h0, write_done_flag}, 8'h00);
        full_write(8'h01, 8'hA5);
        wait_idle();
        wr(8'h9A, 8'h00);
        readback(8'h81, 8'h5A);
        readback(8'h01, 8'hA5);
        $display("write test done");
    endtask
    task automatic t_refused;
        wr(8'h9C, 8'h00);
        unlock(2, 8'h02);
        chk({7'h0, write_busy}, 8'h00);
        wr(8'h9C, 8'h04);
        unlock(1, 8'h06);
        chk({7'h0, write_busy}, 8'h00);
        unlock(3, 8'h06);
        chk({7'h0, write_busy}, 8'h00);
        $display("refusal test done");
    endtask
    task automatic t_abort;
        full_write(8'h01, 8'h77);
        rst         = 1'b1;
        abort_reset = 1'b1;
        @(negedge core_clk);
        rst         = 1'b0;
        abort_reset = 1'b0;
        rd(8'h9C, 8'h08, 8'h08);
        rd(8'h9B, 8'hFF, 8'h01);
        rd(8'h9A, 8'hFF, 8'h77);
        $display("abort test done");
    endtask

    // main sequence after 4 reset cycles
    initial begin
        repeat (4) @(negedge core_clk);
        rst = 1'b0;
        por = 1'b0;
        t_reset();
        t_write();
        t_refused();
        t_abort();
        end_sim();
    end
    // watchdog, far beyond the roughly 150 cycles needed
    initial begin
        #20000;
        err_total++;
        end_sim();
    end
endmodule
`default_nettype wire
